/* hw/rqsd_defines.svh */
// Purpose: Named offsets, field positions, reset values and sizes for the receive steering engine
// Assumes: 12-bit APB byte address, 32-bit data, one word per register
// Notes: Definitions only
`ifndef RQSD_DEFINES_SVH
`define RQSD_DEFINES_SVH

// ==========================================================
// Register byte offsets and decode pages
`define RQSD_OFF_CTRL 12'h000
`define RQSD_OFF_GBSIZE 12'h004
`define RQSD_OFF_RXPB 12'h008
`define RQSD_OFF_DEFPOOL 12'h00C
`define RQSD_OFF_HASH 12'h010
`define RQSD_OFF_FILL 12'h014
`define RQSD_KEY_PAGE 6'h01
`define RQSD_KEY_WORDS 4'hA
`define RQSD_QCTL_PAGE 7'h04
`define RQSD_MAC_PAGE 5'h02
`define RQSD_REDIRECTION_TABLE_PAGE 3'h1

// ==========================================================
// Field positions
`define RQSD_CTRL_HASH_EN 0
`define RQSD_CTRL_VQ_MODE 1
`define RQSD_MAC_VALID 31
`define RQSD_MAC_POOL_LSB 18
`define RQSD_QCTL_HDR_LSB 8
`define RQSD_QCTL_FMT_LSB 16
`define RQSD_ST_DONE 0
`define RQSD_ST_EOP 1

// ==========================================================
// Reset values and sizes
`define RQSD_RXPB_RESET 7'd36
`define RQSD_KEY_RESET 320'h6D5A56DA255B0EC24167253D43A38FB0D0CA2BCBAE7B30B477CB2DA38030F20C6A42B73BBEAC01FA
`define RQSD_BYTES_UDP 6'd36
`define RQSD_BYTES_ADDR 6'd32
`define RQSD_GB_2048 17'h00800
`define RQSD_GB_1024 17'h00400
`define RQSD_GB_512 17'h00200
`define RQSD_GB_256 17'h00100
`define RQSD_FMT_LEGACY 3'h0

`endif

/* hw/rqsd_pkg.sv */
// Purpose: Shared types of the receive steering engine
// Assumes: Nothing beyond SystemVerilog packages
// Notes: Engine phases are one-hot
package rqsd_pkg;

  // ==========================================================
  // Engine phase
  typedef enum logic [4:0] {
    PH_IDLE = 5'b00001,
    PH_HASH = 5'b00010,
    PH_STEER = 5'b00100,
    PH_DATA = 5'b01000,
    PH_WB = 5'b10000
  } rqsd_phase_type;

endpackage : rqsd_pkg

/* hw/rqsd_top.sv */
// Purpose: Receive hash steering, pool association, buffer sizing, descriptor cache and legacy write-back
// Assumes: Header fields and packet bytes arrive from parser logic on pclk
// Notes: APB slave with no wait states; data bytes stream to the host elsewhere
// Functional notes
// - UDP IPv6: hash src, dst, ports (36 bytes)
// - Plain IPv6: hash src then dst (32 bytes)
// - Index 128-entry table by hash bits 6:0
// - Entry is 3-bit queue; off in virtual queues
// - Table rewrites apply live, unsynchronised
// - Key resets to published test key
// - 16 MAC filters pick pool, else default
// - Zero per-queue size selects global size
// - Global size 256, 512, 1024, 2048 bytes
// - Per-queue size 1 KB to 127 KB
// - Header buffer 64 to 4032, 64 steps
// - Buffer addresses accepted at any alignment
// - On-chip buffer 36 KB, size register adjustable
// - 16-entry descriptor cache per queue
// - Format 000b selects legacy descriptor
// - Legacy qword layout: len,csum,status,err,vlan
// - Length counts bytes in this buffer
// - Fragment sum from L4 start, no CRC
// - Status byte bit assignment as listed
// - Done/end flag pairs per descriptor position
// - MAC filter changes take effect per packet
// - Bitwise key-window XOR hash, 320-bit key
// - Unparsable packets get queue 0, hash 0
`timescale 1ns/1ps
`include "rqsd_defines.svh"

module rqsd_top #(
  parameter int QN = 8,
  parameter int CN = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hdr_valid,
  input wire logic hdr_parse_ok,
  input wire logic hdr_ipv6,
  input wire logic hdr_udp,
  input wire logic [127:0] hdr_src_addr,
  input wire logic [127:0] hdr_dst_addr,
  input wire logic [15:0] hdr_src_port,
  input wire logic [15:0] hdr_dst_port,
  input wire logic [47:0] hdr_dest_mac,
  input wire logic [7:0] hdr_status,
  input wire logic [7:0] hdr_errors,
  input wire logic [15:0] hdr_vlan_tag,
  output logic steer_valid,
  output logic [2:0] steer_queue,
  output logic [2:0] steer_pool,
  output logic [31:0] steer_hash,
  output logic [11:0] header_buffer_bytes,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  input wire logic rx_crc,
  input wire logic rx_l4,
  output logic rx_ready,
  input wire logic fetch_valid,
  input wire logic [2:0] fetch_queue,
  input wire logic [63:0] fetch_addr,
  output logic fetch_ready,
  output logic wb_valid,
  input wire logic wb_ready,
  output logic [2:0] wb_queue,
  output logic [63:0] wb_buffer_addr,
  output logic [63:0] wb_status_qword,
  output logic wb_legacy,
  output rqsd_pkg::rqsd_phase_type engine_phase
);
  import rqsd_pkg::*;

  localparam int CW = $clog2(CN);

  // ==========================================================
  // State record
  typedef struct packed {
    rqsd_phase_type st;
    logic hash_en;
    logic vq_mode;
    logic [1:0] gbsize;
    logic [6:0] rxpb_kb;
    logic [2:0] def_pool;
    logic [319:0] key;
    logic [QN-1:0][18:0] qctl;
    logic [15:0][31:0] mac_lo;
    logic [15:0][31:0] mac_hi;
    logic [127:0][2:0] redirection_table;
    logic [287:0] hin;
    logic [319:0] hkey;
    logic [31:0] hres;
    logic [5:0] hcnt;
    logic p_hashable;
    logic [7:0] p_status;
    logic [7:0] p_err;
    logic [15:0] p_vlan;
    logic [16:0] blen;
    logic [16:0] bsize;
    logic [15:0] csum;
    logic codd;
    logic last_seen;
    logic [QN-1:0][CN-1:0][63:0] caddr;
    logic [QN-1:0][CW-1:0] chead;
    logic [QN-1:0][CW:0] ccnt;
    logic [16:0] fill;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic steer_valid;
    logic [2:0] steer_queue;
    logic [2:0] steer_pool;
    logic [31:0] steer_hash;
    logic [11:0] hdr_bytes;
    logic rx_ready;
    logic fetch_ready;
    logic wb_valid;
    logic [63:0] wb_addr;
    logic [63:0] wb_qword;
    logic wb_legacy;
  } rqsd_state_type;

  rqsd_state_type s_r;
  rqsd_state_type s_nxt;
  logic [31:0] rd_data;
  logic rd_hit;

  // ==========================================================
  // Register read decode; key word 0 is the leftmost key byte group
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    if (paddr == `RQSD_OFF_CTRL) begin
      rd_data[`RQSD_CTRL_HASH_EN] = s_r.hash_en;
      rd_data[`RQSD_CTRL_VQ_MODE] = s_r.vq_mode;
    end else if (paddr == `RQSD_OFF_GBSIZE) begin
      rd_data[1:0] = s_r.gbsize;
    end else if (paddr == `RQSD_OFF_RXPB) begin
      rd_data[6:0] = s_r.rxpb_kb;
    end else if (paddr == `RQSD_OFF_DEFPOOL) begin
      rd_data[2:0] = s_r.def_pool;
    end else if (paddr == `RQSD_OFF_HASH) begin
      rd_data = s_r.steer_hash;
    end else if (paddr == `RQSD_OFF_FILL) begin
      rd_data[16:0] = s_r.fill;
    end else if (paddr[11:6] == `RQSD_KEY_PAGE && paddr[5:2] < `RQSD_KEY_WORDS) begin
      rd_data = s_r.key[(9 - int'(paddr[5:2])) * 32 +: 32];
    end else if (paddr[11:5] == `RQSD_QCTL_PAGE && int'(paddr[4:2]) < QN) begin
      rd_data[18:0] = s_r.qctl[paddr[4:2]];
    end else if (paddr[11:7] == `RQSD_MAC_PAGE) begin
      rd_data = paddr[2] ? s_r.mac_hi[paddr[6:3]] : s_r.mac_lo[paddr[6:3]];
    end else if (paddr[11:9] == `RQSD_REDIRECTION_TABLE_PAGE) begin
      rd_data[2:0] = s_r.redirection_table[paddr[8:2]];
    end else begin
      rd_hit = 1'b0;
    end
  end

  // ==========================================================
  // Next-state logic of the whole engine
  always_comb begin
    logic [31:0] acc;
    logic [2:0] q;
    logic [2:0] pool;
    logic hit;
    logic acc_byte;
    logic [16:0] blen_new;
    logic [16:0] sum17;
    logic [15:0] word;
    logic [5:0] hsize;
    logic [6:0] pk;
    logic [CW-1:0] widx;
    logic all_room;
    acc = 32'h0000_0000;
    q = 3'h0;
    pool = 3'h0;
    hit = 1'b0;
    acc_byte = 1'b0;
    blen_new = 17'h0_0000;
    sum17 = 17'h0_0000;
    word = 16'h0000;
    hsize = 6'h00;
    pk = 7'h00;
    widx = '0;
    all_room = 1'b1;
    s_nxt = s_r;
    s_nxt.steer_valid = 1'b0;

    // APB: setup cycle loads read data, access cycle commits the write
    if (psel && !penable) begin
      s_nxt.pready = 1'b1;
      s_nxt.prdata = rd_data;
      s_nxt.pslverr = !rd_hit;
    end else if (psel && penable && s_r.pready) begin
      s_nxt.pready = 1'b0;
      if (pwrite && rd_hit) begin
        if (paddr == `RQSD_OFF_CTRL) begin
          s_nxt.hash_en = pwdata[`RQSD_CTRL_HASH_EN];
          s_nxt.vq_mode = pwdata[`RQSD_CTRL_VQ_MODE];
        end else if (paddr == `RQSD_OFF_GBSIZE) begin
          s_nxt.gbsize = pwdata[1:0];
        end else if (paddr == `RQSD_OFF_RXPB) begin
          s_nxt.rxpb_kb = pwdata[6:0];
        end else if (paddr == `RQSD_OFF_DEFPOOL) begin
          s_nxt.def_pool = pwdata[2:0];
        end else if (paddr[11:6] == `RQSD_KEY_PAGE) begin
          s_nxt.key[(9 - int'(paddr[5:2])) * 32 +: 32] = pwdata;
        end else if (paddr[11:5] == `RQSD_QCTL_PAGE) begin
          s_nxt.qctl[paddr[4:2]] = pwdata[18:0];
        end else if (paddr[11:7] == `RQSD_MAC_PAGE) begin
          if (paddr[2]) begin
            s_nxt.mac_hi[paddr[6:3]] = pwdata;
          end else begin
            s_nxt.mac_lo[paddr[6:3]] = pwdata;
          end
        end else if (paddr[11:9] == `RQSD_REDIRECTION_TABLE_PAGE) begin
          s_nxt.redirection_table[paddr[8:2]] = pwdata[2:0]; // Live, no packet sync
        end
      end
    end

    // Packet engine
    unique case (s_r.st)
      PH_IDLE: begin
        if (hdr_valid) begin
          // Filters sampled once per packet, so edits land between packets
          pool = s_r.def_pool;
          for (int i = 15; i >= 0; i--) begin
            if (s_r.mac_hi[i][`RQSD_MAC_VALID] && {s_r.mac_hi[i][15:0], s_r.mac_lo[i]} == hdr_dest_mac) begin
              pool = s_r.mac_hi[i][`RQSD_MAC_POOL_LSB +: 3];
            end
          end
          s_nxt.steer_pool = pool;
          s_nxt.hin = {hdr_src_addr, hdr_dst_addr, hdr_udp ? {hdr_src_port, hdr_dst_port} : 32'h0000_0000};
          s_nxt.hcnt = hdr_udp ? `RQSD_BYTES_UDP : `RQSD_BYTES_ADDR;
          s_nxt.hkey = s_r.key;
          s_nxt.hres = 32'h0000_0000;
          s_nxt.p_hashable = hdr_parse_ok && hdr_ipv6 && s_r.hash_en && !s_r.vq_mode;
          s_nxt.p_status = hdr_status;
          s_nxt.p_err = hdr_errors;
          s_nxt.p_vlan = hdr_vlan_tag;
          s_nxt.csum = 16'h0000;
          s_nxt.codd = 1'b0;
          s_nxt.st = PH_HASH;
        end
      end
      PH_HASH: begin
        // One input byte per cycle: each set bit folds in the key window at its position
        acc = s_r.hres;
        for (int j = 0; j < 8; j++) begin
          if (s_r.hin[287 - j]) begin
            acc = acc ^ s_r.hkey[319 - j -: 32];
          end
        end
        s_nxt.hres = acc;
        s_nxt.hin = {s_r.hin[279:0], 8'h00};
        s_nxt.hkey = {s_r.hkey[311:0], 8'h00};
        s_nxt.hcnt = s_r.hcnt - 6'd1;
        if (s_r.hcnt == 6'd1) begin
          s_nxt.st = PH_STEER;
        end
      end
      PH_STEER: begin
        q = s_r.p_hashable ? s_r.redirection_table[s_r.hres[6:0]] : 3'h0;
        s_nxt.steer_queue = q;
        s_nxt.steer_hash = s_r.p_hashable ? s_r.hres : 32'h0000_0000;
        s_nxt.steer_valid = 1'b1;
        pk = s_r.qctl[q][6:0];
        if (pk != 7'h00) begin
          s_nxt.bsize = {pk, 10'h000}; // 1 KB steps up to 127 KB
        end else begin
          unique case (s_r.gbsize)
            2'b00: s_nxt.bsize = `RQSD_GB_2048;
            2'b01: s_nxt.bsize = `RQSD_GB_1024;
            2'b10: s_nxt.bsize = `RQSD_GB_512;
            2'b11: s_nxt.bsize = `RQSD_GB_256;
          endcase
        end
        hsize = s_r.qctl[q][`RQSD_QCTL_HDR_LSB +: 6];
        s_nxt.hdr_bytes = {hsize, 6'h00};
        s_nxt.blen = 17'h0_0000;
        s_nxt.last_seen = 1'b0;
        s_nxt.st = PH_DATA;
      end
      PH_DATA: begin
        acc_byte = rx_valid && s_r.rx_ready;
        if (acc_byte) begin
          blen_new = s_r.blen + 17'd1;
          s_nxt.blen = blen_new; // CRC bytes counted too
          s_nxt.fill = s_r.fill + 17'd1;
          if (rx_l4 && !rx_crc) begin
            word = s_r.codd ? {8'h00, rx_data} : {rx_data, 8'h00};
            sum17 = {1'b0, s_r.csum} + {1'b0, word};
            s_nxt.csum = sum17[15:0] + {15'h0000, sum17[16]}; // End-around carry
            s_nxt.codd = !s_r.codd;
          end
          if (blen_new == s_r.bsize || rx_last) begin
            // Raised only after the buffer's last byte, so done never leads its data
            s_nxt.last_seen = rx_last;
            s_nxt.wb_valid = 1'b1;
            s_nxt.wb_addr = s_r.caddr[s_r.steer_queue][s_r.chead[s_r.steer_queue]]; // Unaligned ok
            s_nxt.wb_legacy = s_r.qctl[s_r.steer_queue][`RQSD_QCTL_FMT_LSB +: 3] == `RQSD_FMT_LEGACY;
            s_nxt.wb_qword = 64'h0000_0000_0000_0000;
            s_nxt.wb_qword[15:0] = blen_new[15:0];
            s_nxt.wb_qword[32 + `RQSD_ST_DONE] = 1'b1;
            if (rx_last) begin
              s_nxt.wb_qword[31:16] = s_nxt.csum;
              s_nxt.wb_qword[39:32] = {s_r.p_status[7:3], 1'b0, 2'b11}; // Reserved bit 2 kept clear
              s_nxt.wb_qword[47:40] = s_r.p_err;
              s_nxt.wb_qword[63:48] = s_r.p_vlan;
            end
            s_nxt.st = PH_WB;
          end
        end
      end
      PH_WB: begin
        if (wb_ready) begin
          // Buffer consumed: release on-chip space and retire the cached descriptor
          s_nxt.wb_valid = 1'b0;
          s_nxt.fill = s_r.fill - s_r.blen;
          s_nxt.chead[s_r.steer_queue] = s_r.chead[s_r.steer_queue] + 1'b1;
          s_nxt.ccnt[s_r.steer_queue] = s_r.ccnt[s_r.steer_queue] - 1'b1;
          s_nxt.blen = 17'h0_0000;
          s_nxt.st = s_r.last_seen ? PH_IDLE : PH_DATA;
        end
      end
      default: begin
        s_nxt.st = PH_IDLE;
      end
    endcase

    // Descriptor fetch fills the per-queue cache in arrival order
    if (fetch_valid && s_r.fetch_ready) begin
      widx = s_nxt.chead[fetch_queue] + s_nxt.ccnt[fetch_queue][CW-1:0];
      s_nxt.caddr[fetch_queue][widx] = fetch_addr; // Address kept bit for bit
      s_nxt.ccnt[fetch_queue] = s_nxt.ccnt[fetch_queue] + 1'b1;
    end
    for (int k = 0; k < QN; k++) begin
      if (s_nxt.ccnt[k] >= (CW + 1)'(CN)) begin
        all_room = 1'b0;
      end
    end
    s_nxt.fetch_ready = all_room; // One ready for all queues keeps it a pure flop output

    // Byte intake needs a cached descriptor and room in the on-chip buffer
    s_nxt.rx_ready = (s_nxt.st == PH_DATA) && (s_nxt.ccnt[s_nxt.steer_queue] != '0) &&
                     (s_nxt.fill < {s_r.rxpb_kb, 10'h000});
  end

  // ==========================================================
  // State register; tables come up zeroed and the key at the test key
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.st <= PH_IDLE;
      s_r.key <= `RQSD_KEY_RESET;
      s_r.rxpb_kb <= `RQSD_RXPB_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Outputs straight from the state record
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign steer_valid = s_r.steer_valid;
  assign steer_queue = s_r.steer_queue;
  assign steer_pool = s_r.steer_pool;
  assign steer_hash = s_r.steer_hash;
  assign header_buffer_bytes = s_r.hdr_bytes;
  assign rx_ready = s_r.rx_ready;
  assign fetch_ready = s_r.fetch_ready;
  assign wb_valid = s_r.wb_valid;
  assign wb_queue = s_r.steer_queue;
  assign wb_buffer_addr = s_r.wb_addr;
  assign wb_status_qword = s_r.wb_qword;
  assign wb_legacy = s_r.wb_legacy;
  assign engine_phase = s_r.st;

endmodule : rqsd_top

/* tb/rqsd_monitor.sv */
// Purpose: Port checks of the receive steering engine
// Assumes: Bound into rqsd_top; one clock domain
// Notes: Byte counter restarts at each accepted write-back
`timescale 1ns/1ps
module rqsd_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic hdr_valid,
  input wire logic hdr_parse_ok,
  input wire logic hdr_ipv6,
  input wire logic hdr_udp,
  input wire logic steer_valid,
  input wire logic [2:0] steer_queue,
  input wire logic [31:0] steer_hash,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic wb_valid,
  input wire logic wb_ready,
  input wire logic [63:0] wb_buffer_addr,
  input wire logic [63:0] wb_status_qword,
  input rqsd_pkg::rqsd_phase_type engine_phase
);
  import rqsd_pkg::*;
  // ==========================================
  // Helper logic
  logic [16:0] cnt_r;
  logic [16:0] cnt_nxt;
  logic take;
  // A header only counts when the engine idles
  assign take = hdr_valid && engine_phase == PH_IDLE;
  // Bytes taken since the last accepted write-back
  always_comb begin
    cnt_nxt = cnt_r;
    if (wb_valid && wb_ready) cnt_nxt = '0;
    else if (rx_valid && rx_ready) cnt_nxt = cnt_r + 17'h00001;
  end
  // Counter register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_r <= '0;
    else cnt_r <= cnt_nxt;
  end
  // ==========================================
  // Assertions
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_udp_lat;
    take && hdr_parse_ok && hdr_ipv6 && hdr_udp |-> ##38 steer_valid;
  endproperty
  a_udp_lat: assert property (p_udp_lat) else $error("udp steer answer off time");
  property p_plain_lat;
    take && hdr_parse_ok && hdr_ipv6 && !hdr_udp |-> ##34 steer_valid;
  endproperty
  a_plain_lat: assert property (p_plain_lat) else $error("address steer answer off time");
  property p_unparsed;
    take && !(hdr_parse_ok && hdr_ipv6) |-> ##[34:38] (steer_valid && steer_queue == 3'h0 && steer_hash == 32'h0);
  endproperty
  a_unparsed: assert property (p_unparsed) else $error("unparsed packet not zero steered");
  property p_done;
    wb_valid |-> wb_status_qword[32];
  endproperty
  a_done: assert property (p_done) else $error("write-back without done flag");
  property p_rsv;
    wb_valid |-> !wb_status_qword[34];
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved status bit set");
  property p_hold;
    wb_valid && !wb_ready |=> wb_valid && $stable(wb_status_qword) && $stable(wb_buffer_addr);
  endproperty
  a_hold: assert property (p_hold) else $error("write-back changed while stalled");
  property p_no_rx;
    wb_valid |-> !rx_ready;
  endproperty
  a_no_rx: assert property (p_no_rx) else $error("bytes taken during write-back");
  property p_len;
    $rose(wb_valid) |-> wb_status_qword[15:0] == cnt_r[15:0];
  endproperty
  a_len: assert property (p_len) else $error("length differs from bytes taken");
endmodule : rqsd_monitor

bind rqsd_top rqsd_monitor u_monitor (
  .pclk(pclk), .presetn(presetn), .hdr_valid(hdr_valid), .hdr_parse_ok(hdr_parse_ok),
  .hdr_ipv6(hdr_ipv6), .hdr_udp(hdr_udp), .steer_valid(steer_valid), .steer_queue(steer_queue),
  .steer_hash(steer_hash), .rx_valid(rx_valid), .rx_ready(rx_ready), .wb_valid(wb_valid),
  .wb_ready(wb_ready), .wb_buffer_addr(wb_buffer_addr), .wb_status_qword(wb_status_qword),
  .engine_phase(engine_phase)
);

/* tb/rqsd_host_model.sv */
// Purpose: Host side: descriptor hand-over and write-back acceptance
// Assumes: Bench calls push right after a clock edge
// Notes: Acceptance stalls at random to exercise held write-backs
`timescale 1ns/1ps
module rqsd_host_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fetch_ready,
  input wire logic wb_valid,
  output logic fetch_valid,
  output logic [2:0] fetch_queue,
  output logic [63:0] fetch_addr,
  output logic wb_ready
);
  // ==========================================
  // Descriptor hand-over
  // Idle at time zero
  initial begin
    fetch_valid = 1'b0;
    fetch_queue = 3'h0;
    fetch_addr = 64'h0;
  end
  // Fresh descriptors carry no done or end flags; any address alignment is used
  task automatic push(input logic [2:0] q, input logic [63:0] a, input int n);
    for (int i = 0; i < n; i++) begin
      fetch_valid <= 1'b1;
      fetch_queue <= q;
      fetch_addr <= a + 64'(2 * i);
      do @(posedge pclk); while (!fetch_ready);
    end
    fetch_valid <= 1'b0;
    fetch_queue <= ~q;
    fetch_addr <= ~a;
  endtask : push
  // ==========================================
  // Write-back acceptance
  // Random stalls; a slow host is legal
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) wb_ready <= 1'b0;
    else wb_ready <= ($urandom % 3) != 0;
  end
endmodule : rqsd_host_model

/* tb/tb_rx_queue_steer_descriptor_wb.sv */
// Purpose: Self-checking bench of the receive steering engine
// Assumes: Host model answers fetch and write-back
// Notes: Fixed seed; reference hash vectors among random packets
`timescale 1ns/1ps
`include "rqsd_defines.svh"
module tb_rx_queue_steer_descriptor_wb;
  import rqsd_pkg::*;
  // ==========================================
  // Signals and bench state
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, rx_valid, rx_last, rx_crc, rx_l4, rx_ready, er;
  logic hdr_valid, hdr_parse_ok, hdr_ipv6, hdr_udp, steer_valid, fetch_valid, fetch_ready, wb_valid, wb_ready;
  logic wb_legacy;
  logic [11:0] paddr, header_buffer_bytes;
  logic [31:0] pwdata, prdata, steer_hash, rd;
  logic [127:0] hdr_src_addr, hdr_dst_addr;
  logic [15:0] hdr_src_port, hdr_dst_port, hdr_vlan_tag;
  logic [47:0] hdr_dest_mac, fmac;
  logic [7:0] hdr_status, hdr_errors, rx_data;
  logic [2:0] steer_queue, steer_pool, fetch_queue, wb_queue, fpool, dpool;
  logic [63:0] fetch_addr, wb_buffer_addr, wb_status_qword;
  rqsd_phase_type engine_phase;
  logic [2:0] ret [128];
  logic [5:0] hu [8];
  logic [2:0] fm [8];
  logic [6:0] pk [8];
  logic [131:0] wbq [$];
  logic [1:0] ctl, gsz;
  int num_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int k;

  rqsd_top dut (.*);
  rqsd_host_model host (.*);

  // 50 MHz clock
  always #10 pclk = ~pclk;
  // Record accepted write-backs; cut a hang short
  always @(posedge pclk) begin
    if (wb_valid && wb_ready) wbq.push_back({wb_legacy, wb_queue, wb_buffer_addr, wb_status_qword});
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      conclude();
    end
  end
  // ==========================================
  // Tasks and functions
  task automatic conclude();
    if (num_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  // One APB transfer; an idle edge first keeps psel from being set twice at once
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (!pready);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic qset(input int q);
    apb(1'b1, {7'h04, 3'(q), 2'h0}, {13'h0, fm[q], 2'h0, hu[q], 1'b0, pk[q]});
  endtask : qset

  // Bitwise keyed hash, input left-aligned in d
  function automatic logic [31:0] toe(input logic [287:0] d, input int nb);
    logic [319:0] key;
    toe = 32'h0;
    key = `RQSD_KEY_RESET;
    for (int i = 0; i < nb; i++) begin
      if (d[287 - i]) toe ^= key[319 -: 32];
      key = key << 1;
    end
  endfunction : toe

  // Header, steering check, descriptors, byte stream, write-back checks
  task automatic pkt(input logic u, input logic ok, input int len);
    logic [31:0] h, s;
    logic [63:0] a;
    logic [131:0] e;
    logic [7:0] b;
    logic [2:0] q;
    int bs, n, m;
    hdr_valid <= 1'b1;
    hdr_udp <= u;
    hdr_parse_ok <= ok;
    @(posedge pclk);
    hdr_valid <= 1'b0;
    h = 32'h0;
    if (ok && hdr_ipv6 && ctl == 2'h1) h = toe({hdr_src_addr, hdr_dst_addr, u ? {hdr_src_port, hdr_dst_port} : 32'h0}, u ? 288 : 256);
    q = (ok && hdr_ipv6 && ctl == 2'h1) ? ret[h[6:0]] : 3'h0;
    n = 0;
    while (!steer_valid && n < 60) begin
      @(posedge pclk);
      n++;
    end
    chk("hash", h, steer_hash);
    chk("queue", q, steer_queue);
    chk("pool", hdr_dest_mac == fmac ? fpool : dpool, steer_pool);
    chk("hdr_bytes", {hu[q], 6'h0}, header_buffer_bytes);
    bs = pk[q] != 7'h0 ? pk[q] * 1024 : 2048 >> gsz;
    n = (len + bs - 1) / bs;
    a = {$urandom, $urandom};
    a[0] &= fm[q] == 3'h0;
    host.push(q, a, n);
    s = 32'h0;
    m = 0;
    for (int i = 0; i < len; i++) begin
      b = 8'($urandom);
      if (i >= 2 && i < len - 4) begin
        s += (m % 2) ? {24'h0, b} : {16'h0, b, 8'h0};
        m++;
      end
      rx_valid <= 1'b1;
      rx_data <= b;
      rx_last <= i == len - 1;
      rx_crc <= i >= len - 4;
      rx_l4 <= i >= 2;
      do @(posedge pclk); while (!rx_ready);
    end
    rx_valid <= 1'b0;
    rx_data <= ~b;
    do @(posedge pclk); while (engine_phase !== PH_IDLE);
    s = s[15:0] + s[31:16];
    s = s[15:0] + s[31:16];
    chk("wb_count", n, wbq.size());
    for (int j = 0; j < n && wbq.size() > 0; j++) begin
      e = wbq.pop_front();
      m = len - j * bs > bs ? bs : len - j * bs;
      chk("wb_len", m, e[15:0]);
      chk("wb_flags", {j == n - 1, 1'b1}, e[33:32]);
      chk("wb_addr", a + 64'(2 * j), e[127:64]);
      chk("wb_queue", {fm[q] == 3'h0, q}, e[131:128]);
      if (j == n - 1) chk("wb_tail", {hdr_vlan_tag, hdr_errors, hdr_status[7:3], 3'b011, s[15:0]}, e[63:16]);
    end
    wbq.delete();
  endtask : pkt
  // ==========================================
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, hdr_valid, hdr_parse_ok, hdr_udp} = '0;
    {hdr_src_addr, hdr_dst_addr, hdr_src_port, hdr_dst_port, hdr_dest_mac} = '0;
    {hdr_status, hdr_errors, hdr_vlan_tag, rx_valid, rx_data, rx_last, rx_crc, rx_l4} = '0;
    hdr_ipv6 = 1'b1;
    void'($urandom(32'h71B1));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h008, 32'h0);
    chk("rx_buffer_reset", 32'h00000024, rd);
    apb(1'b0, 12'h040, 32'h0);
    chk("key_word0", 32'h6D5A56DA, rd);
    apb(1'b0, 12'h018, 32'h0);
    chk("unmapped", 33'h100000000, {er, rd});
    ctl = 2'h1;
    gsz = 2'h3;
    fmac = {$urandom, 16'h5A5A};
    fpool = 3'($urandom);
    dpool = ~fpool;
    apb(1'b1, 12'h000, {30'h0, ctl});
    apb(1'b1, 12'h004, {30'h0, gsz});
    apb(1'b1, 12'h00C, {29'h0, dpool});
    k = $urandom % 16;
    apb(1'b1, {5'h02, 4'(k), 3'h0}, fmac[31:0]);
    apb(1'b1, {5'h02, 4'(k), 3'h4}, {1'b1, 10'h0, fpool, 2'h0, fmac[47:32]});
    for (int i = 0; i < 8; i++) begin
      hu[i] = 6'($urandom % 32 + 1);
      fm[i] = 3'($urandom % 2);
      pk[i] = 7'h00;
      qset(i);
    end
    for (int i = 0; i < 128; i++) begin
      ret[i] = 3'($urandom);
      apb(1'b1, {3'h1, 7'(i), 2'h0}, {29'h0, ret[i]});
    end
    // Reference vector, with and without ports
    hdr_src_addr <= 128'h3FFE250102001FFF0000000000000007;
    hdr_dst_addr <= 128'h3FFE2501020000030000000000000001;
    {hdr_src_port, hdr_dst_port} <= 32'h0AEA06E6;
    hdr_dest_mac <= fmac;
    pkt(1'b1, 1'b1, 12);
    chk("ref_ports", 32'h40207D3D, steer_hash);
    pkt(1'b0, 1'b1, 12);
    chk("ref_addr", 32'h2CC18CD5, steer_hash);
    // Random packets; table rewritten live between them
    for (int i = 0; i < 12; i++) begin
      k = $urandom % 128;
      ret[k] = 3'($urandom);
      apb(1'b1, {3'h1, 7'(k), 2'h0}, {29'h0, ret[k]});
      hdr_src_addr <= {$urandom, $urandom, $urandom, $urandom};
      hdr_dst_addr <= {$urandom, $urandom, $urandom, $urandom};
      {hdr_src_port, hdr_dst_port} <= $urandom;
      hdr_dest_mac <= i % 2 ? fmac : {$urandom, 16'h0};
      hdr_ipv6 <= i != 7;
      {hdr_status, hdr_errors, hdr_vlan_tag} <= $urandom;
      pkt(i % 3 != 0, i != 5, 8 + $urandom % 33);
    end
    // Virtual queue mode turns steering off
    ctl = 2'h3;
    apb(1'b1, 12'h000, {30'h0, ctl});
    pkt(1'b0, 1'b1, 16);
    ctl = 2'h1;
    apb(1'b1, 12'h000, {30'h0, ctl});
    // Every global size, one byte stream spilling past a buffer
    for (int g = 0; g < 4; g++) begin
      gsz = 2'(g);
      apb(1'b1, 12'h004, {30'h0, gsz});
      pkt(1'b1, 1'b1, (2048 >> g) + 5);
    end
    for (int i = 0; i < 8; i++) begin
      pk[i] = 7'h01;
      qset(i);
    end
    pkt(1'b1, 1'b1, 1030);
    apb(1'b0, 12'h014, 32'h0);
    chk("fill", 32'h0, rd);
    conclude();
  end
endmodule : tb_rx_queue_steer_descriptor_wb
